// ### design/identity_pkg.sv
package identity_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] ID_WORD_OFFSET = 12'h004;
  localparam logic [11:0] ERR_STATUS_OFFSET = 12'h0f0;
  localparam logic [11:0] ERR_CTRL_OFFSET = 12'h0f4;

  // identity word field positions (lsb of each field)
  localparam int LAYOUT_REVISION_LSB = 28;
  localparam int PRODUCT_LINE_LSB = 24;
  localparam int COMPONENT_CODE_LSB = 16;
  localparam int TERMINAL_TALLY_LSB = 13;
  localparam int RESERVED_LSB = 8;
  localparam int THERMAL_GRADE_LSB = 5;
  localparam int HOUSING_TYPE_LSB = 3;
  localparam int LEAD_FREE_LSB = 2;
  localparam int RELEASE_GRADE_LSB = 0;

  // fixed identity field values
  localparam logic [3:0] LAYOUT_REVISION_VAL = 4'h1;
  localparam logic [2:0] TERMINAL_TALLY_VAL = 3'h2;
  localparam logic [4:0] RESERVED_VAL = 5'h00;
  localparam logic LEAD_FREE_VAL = 1'b1;

  // thermal grade codes
  localparam logic [2:0] THERMAL_COMMERCIAL = 3'h0;
  localparam logic [2:0] THERMAL_INDUSTRIAL = 3'h1;
  localparam logic [2:0] THERMAL_EXTENDED = 3'h2;

  // housing type codes
  localparam logic [1:0] HOUSING_SMALL_OUTLINE = 2'h0;
  localparam logic [1:0] HOUSING_QUAD_FLAT = 2'h1;
  localparam logic [1:0] HOUSING_BALL_GRID = 2'h2;

  // release grade codes
  localparam logic [1:0] RELEASE_ENGINEERING = 2'h0;
  localparam logic [1:0] RELEASE_PILOT = 2'h1;
  localparam logic [1:0] RELEASE_QUALIFIED = 2'h2;

  // error register layout and reset values
  localparam int UNMAPPED_SEEN_BIT = 0;
  localparam int ERR_RESPONSE_EN_BIT = 0;
  localparam logic ERR_RESPONSE_EN_RST = 1'b1;
  localparam logic UNMAPPED_SEEN_RST = 1'b0;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

endpackage : identity_pkg

// ### design/identity_word_hold.sv
`timescale 1ns/1ps

// holds the assembled identity word; per-part values are tie-offs
module identity_word_hold #(
  parameter logic [3:0] PRODUCT_LINE_CODE = 4'h7,
  parameter logic [7:0] COMPONENT_CODE = 8'h5a,
  parameter logic [2:0] THERMAL_GRADE = identity_pkg::THERMAL_INDUSTRIAL,
  parameter logic [1:0] HOUSING_TYPE = identity_pkg::HOUSING_QUAD_FLAT,
  parameter logic [1:0] RELEASE_GRADE = identity_pkg::RELEASE_QUALIFIED
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  output logic [31:0] word // identity word
);

  localparam logic [31:0] WORD_VAL = {
    identity_pkg::LAYOUT_REVISION_VAL,
    PRODUCT_LINE_CODE,
    COMPONENT_CODE,
    identity_pkg::TERMINAL_TALLY_VAL,
    identity_pkg::RESERVED_VAL,
    THERMAL_GRADE,
    HOUSING_TYPE,
    identity_pkg::LEAD_FREE_VAL,
    RELEASE_GRADE
  };

  logic [31:0] word_q;
  logic [31:0] word_d;

  // the word never changes: next value is the constant itself
  always_comb begin
    word_d = WORD_VAL;
  end

  // constant from reset onward, no write path exists
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_q <= WORD_VAL;
    end else begin
      word_q <= word_d;
    end
  end

  assign word = word_q;

endmodule : identity_word_hold

// ### design/device_identity_register.sv
`timescale 1ns/1ps

// How it works
// - identity word is read-only at 0x004; writes change nothing
// - bits 31:28 return layout revision 0x1
// - bits 27:24 return the product line code
// - bits 23:16 return the component code
// - bits 15:13 return terminal tally code 0x2
// - bits 12:8 always read zero
// - bits 7:5 return the thermal grade code
// - bits 4:3 return the housing type code
// - bit 2 returns the lead-free flag, set on this part
// - bits 1:0 return the release grade code
module device_identity_register #(
  // arbitrary neutral value
  parameter logic [3:0] PRODUCT_LINE_CODE = 4'h7,
  // arbitrary neutral value
  parameter logic [7:0] COMPONENT_CODE = 8'h5a,
  parameter logic [2:0] THERMAL_GRADE = identity_pkg::THERMAL_INDUSTRIAL,
  parameter logic [1:0] HOUSING_TYPE = identity_pkg::HOUSING_QUAD_FLAT,
  parameter logic [1:0] RELEASE_GRADE = identity_pkg::RELEASE_QUALIFIED
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 = write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error
);

  ////////////////////////////////////////////////////////////////////////
  // identity word source

  logic [31:0] id_word;

  identity_word_hold #(
    .PRODUCT_LINE_CODE(PRODUCT_LINE_CODE),
    .COMPONENT_CODE(COMPONENT_CODE),
    .THERMAL_GRADE(THERMAL_GRADE),
    .HOUSING_TYPE(HOUSING_TYPE),
    .RELEASE_GRADE(RELEASE_GRADE)
  ) u_word (
    .mclk(mclk),
    .rst(rst),
    .word(id_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // word-aligned compare; low two address bits are ignored
  function automatic logic hits(input logic [11:0] addr,
                                input logic [11:0] off);
    hits = (addr[11:2] == off[11:2]);
  endfunction : hits

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hits(addr, identity_pkg::ID_WORD_OFFSET) ||
             hits(addr, identity_pkg::ERR_STATUS_OFFSET) ||
             hits(addr, identity_pkg::ERR_CTRL_OFFSET);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////
  // bus slave and error registers

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic unmapped_seen_q;
  logic unmapped_seen_d;
  logic err_en_q;
  logic err_en_d;
  logic setup;
  logic commit;
  logic bad_addr;

  // one wait-free answer: decode in setup, ready during access
  always_comb begin
    setup = psel && !penable;
    commit = psel && penable && pready_q;
    bad_addr = !mapped(paddr);
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    unmapped_seen_d = unmapped_seen_q;
    err_en_d = err_en_q;
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = bad_addr && err_en_q;
      prdata_d = identity_pkg::PRDATA_RST;
      if (!pwrite) begin
        if (hits(paddr, identity_pkg::ID_WORD_OFFSET)) begin
          prdata_d = id_word;
        end else if (hits(paddr, identity_pkg::ERR_STATUS_OFFSET)) begin
          prdata_d[identity_pkg::UNMAPPED_SEEN_BIT] = unmapped_seen_q;
        end else if (hits(paddr, identity_pkg::ERR_CTRL_OFFSET)) begin
          prdata_d[identity_pkg::ERR_RESPONSE_EN_BIT] = err_en_q;
        end
      end
    end else if (pready_q) begin
      prdata_d = prdata_q;
    end
    // writes land only at the edge where ready is sampled
    if (commit && pwrite && pstrb[0]) begin
      if (hits(paddr, identity_pkg::ERR_STATUS_OFFSET) &&
          pwdata[identity_pkg::UNMAPPED_SEEN_BIT]) begin
        unmapped_seen_d = 1'b0;
      end
      if (hits(paddr, identity_pkg::ERR_CTRL_OFFSET)) begin
        err_en_d = pwdata[identity_pkg::ERR_RESPONSE_EN_BIT];
      end
    end
    // a write to the identity word has no target: no branch above takes it
    // set after clear so a fresh bad access is never lost
    if (commit && bad_addr) begin
      unmapped_seen_d = 1'b1;
    end
  end

  // registers only; reset to constants
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_q <= identity_pkg::PRDATA_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      unmapped_seen_q <= identity_pkg::UNMAPPED_SEEN_RST;
      err_en_q <= identity_pkg::ERR_RESPONSE_EN_RST;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      unmapped_seen_q <= unmapped_seen_d;
      err_en_q <= err_en_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : device_identity_register

// ### sim/device_identity_register_properties.sv
`timescale 1ns/1ps
module device_identity_register_properties #(
  parameter logic [3:0] PRODUCT_LINE_CODE = 4'h7,
  parameter logic [7:0] COMPONENT_CODE = 8'h5a,
  parameter logic [2:0] THERMAL_GRADE = 3'h1,
  parameter logic [1:0] HOUSING_TYPE = 2'h1,
  parameter logic [1:0] RELEASE_GRADE = 2'h2
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // completed access to the identity word
  sequence id_done;
    psel && penable && pready && paddr[11:2] == 10'h001;
  endsequence
  sequence id_read;
    id_done ##0 !pwrite;
  endsequence
  a_rev_field: assert property (id_read |-> prdata[31:28] == 4'h1)
    else $error("layout revision wrong");
  a_line_field: assert property (id_read |->
    prdata[27:24] == PRODUCT_LINE_CODE) else $error("line code wrong");
  a_comp_field: assert property (id_read |->
    prdata[23:16] == COMPONENT_CODE) else $error("component wrong");
  a_tally_field: assert property (id_read |-> prdata[15:13] == 3'h2)
    else $error("terminal tally wrong");
  a_resv_zero: assert property (id_read |-> prdata[12:8] == 5'h00)
    else $error("reserved bits set");
  a_thermal_field: assert property (id_read |->
    prdata[7:5] == THERMAL_GRADE) else $error("thermal grade wrong");
  a_housing_field: assert property (id_read |->
    prdata[4:3] == HOUSING_TYPE) else $error("housing wrong");
  a_lead_free: assert property (id_read |-> prdata[2])
    else $error("lead free flag clear");
  a_release_field: assert property (id_read |->
    prdata[1:0] == RELEASE_GRADE) else $error("release grade wrong");
  a_write_quiet: assert property (id_done ##0 pwrite |-> !pslverr)
    else $error("identity write refused");
endmodule : device_identity_register_properties
bind device_identity_register device_identity_register_properties #(
  .PRODUCT_LINE_CODE(PRODUCT_LINE_CODE), .COMPONENT_CODE(COMPONENT_CODE),
  .THERMAL_GRADE(THERMAL_GRADE), .HOUSING_TYPE(HOUSING_TYPE),
  .RELEASE_GRADE(RELEASE_GRADE)) u_props (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### sim/device_identity_register_test.sv
`timescale 1ns/1ps
module device_identity_register_test;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, id;
  logic [3:0] pstrb;
  int miscompares = 0;
  int tests_run = 0;
  // per-part values differ from defaults so wrong tie-offs show up
  device_identity_register #(.PRODUCT_LINE_CODE(4'h3),
    .COMPONENT_CODE(8'h21), .THERMAL_GRADE(identity_pkg::THERMAL_EXTENDED),
    .HOUSING_TYPE(identity_pkg::HOUSING_BALL_GRID),
    .RELEASE_GRADE(identity_pkg::RELEASE_PILOT)) u_device_identity_register (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; no wait-state count assumed, bounded wait instead
  // ready is looked at mid-cycle, where it has settled; the rising edge
  // after that sighting is the one where the transfer completes
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hf};
    @(posedge mclk);
    penable <= 1;
    @(negedge mclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        print_verdict();
      end
      @(negedge mclk);
    end
    rd = prdata;
    er = pslverr;
    @(posedge mclk);
    {psel, penable} <= 2'b00;
  endtask : apb
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    rst = 1;
    id = {4'h1, 4'h3, 8'h21, 3'h2, 5'h00, 3'h2, 2'h2, 1'b1, 2'h1};
    repeat (16) @(posedge mclk);
    chk(prdata, 32'h0000_0000);
    rst <= 0;
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, id);
    chk({31'h0, er}, 32'h0000_0000);
    $display("identity read done");
    // all ones would expose any writable bit, reserved ones included
    apb(1, 12'h004, 32'hffff_ffff);
    chk({31'h0, er}, 32'h0000_0000);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, id);
    $display("identity write done");
    apb(0, 12'h100, 32'h0000_0000);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(0, 12'h0f0, 32'h0000_0000);
    chk({31'h0, rd[0]}, 32'h0000_0001);
    $display("unmapped access done");
    // write one clears the sticky flag
    apb(1, 12'h0f0, 32'h0000_0001);
    apb(0, 12'h0f0, 32'h0000_0000);
    chk({31'h0, rd[0]}, 32'h0000_0000);
    // with the error response off, an unmapped access answers quietly
    apb(1, 12'h0f4, 32'h0000_0000);
    apb(0, 12'h0f4, 32'h0000_0000);
    chk({31'h0, rd[0]}, 32'h0000_0000);
    apb(0, 12'h104, 32'h0000_0000);
    chk({er, rd}, {1'b0, 32'h0000_0000});
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, id);
    $display("error control done");
    print_verdict();
  end
endmodule : device_identity_register_test
